// [hdl/pfh_host.sv]
`timescale 1ns/100ps
`include "pfh_params.svh"
module pfh_host
  import pfh_pkg::*;
#(
  parameter int P_RP_CYC = `PFH_RP_CYC
)(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_op,
  input wire logic [21:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic i_byte_mode,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  output logic o_rsp_err,
  output logic [23:0] o_prot_map,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_reset_n,
  output logic o_reset_hv,
  output logic o_id_hv,
  output logic o_byte_n,
  output logic [20:0] o_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe_n
);

  // ****************************************
  // group decode
  // ****************************************
  // maps address bits 20-12 to a protection group number
  function automatic logic [4:0] grp_of(input logic [8:0] a);
    logic [4:0] g;
    g = 5'h00;
    if (a[8:5] != 4'hF)
      g = {1'b0, a[8:5]};
    else if (a[4:3] != 2'h3)
      g = 5'h0F;
    else
      g = 5'(5'h10 + {2'h0, a[2:0]});
    return g;
  endfunction : grp_of

  // ****************************************
  // pin input synchroniser
  // ****************************************
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;

  // data lines come from the flash with no clock relation
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end
    else
    begin
      dq_s1_reg <= i_dq;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  pfh_state_e state_reg, state_next;
  pfh_op_e op_reg, op_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [4:0] grp_reg, grp_next;
  logic [23:0] prot_reg, prot_next;
  logic ready_reg, ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [15:0] rsp_data_reg, rsp_data_next;
  logic rsp_err_reg, rsp_err_next;
  logic ce_n_reg, ce_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic rst_n_reg, rst_n_next;
  logic rst_hv_reg, rst_hv_next;
  logic id_hv_reg, id_hv_next;
  logic byte_n_reg, byte_n_next;
  logic [20:0] addr_reg, addr_next;
  logic [15:0] dq_o_reg, dq_o_next;
  logic [15:0] dq_oe_n_reg, dq_oe_n_next;

  // next values for the whole pin sequence
  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    grp_next = grp_reg;
    prot_next = prot_reg;
    ready_next = ready_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    rsp_err_next = rsp_err_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    rst_n_next = rst_n_reg;
    rst_hv_next = rst_hv_reg;
    id_hv_next = id_hv_reg;
    byte_n_next = byte_n_reg;
    addr_next = addr_reg;
    dq_o_next = dq_o_reg;
    dq_oe_n_next = dq_oe_n_reg;
    unique case (state_reg)
      PFH_ST_IDLE:
      begin
        if (i_req_valid)
        begin
          ready_next = 1'b0;
          rsp_err_next = 1'b0;
          op_next = pfh_op_e'(i_req_op);
          grp_next = grp_of(i_req_addr[21:13]);
          byte_n_next = ~i_byte_mode;
          addr_next = i_req_addr[21:1];
          cnt_next = 8'h00;
          // byte mode: line 15 carries the low address bit, 8-14 left floating
          dq_o_next = {i_req_addr[0], 15'h0000};
          dq_oe_n_next = i_byte_mode ? 16'h7FFF : 16'hFFFF;
          unique case (pfh_op_e'(i_req_op))
            PFH_OP_READ, PFH_OP_STATUS, PFH_OP_IDREAD:
            begin
              // lanes 0-14 stay released while output enable is low; line 15 stays driven in byte mode
              ce_n_next = 1'b0;
              oe_n_next = 1'b0;
              id_hv_next = (pfh_op_e'(i_req_op) == PFH_OP_IDREAD);
              state_next = PFH_ST_RD;
            end
            PFH_OP_WRITE, PFH_OP_PROTECT, PFH_OP_UNPROT:
            begin
              dq_o_next[14:0] = i_req_wdata[14:0];
              if (!i_byte_mode)
                dq_o_next[15] = i_req_wdata[15];
              dq_oe_n_next = i_byte_mode ? 16'h7F00 : 16'h0000;
              if (pfh_op_e'(i_req_op) != PFH_OP_WRITE)
              begin
                addr_next[`PFH_ADDR_A6] = (pfh_op_e'(i_req_op) == PFH_OP_UNPROT);
                addr_next[`PFH_ADDR_A1] = 1'b1;
                addr_next[`PFH_ADDR_A0] = 1'b0;
                rst_hv_next = 1'b1;
              end
              // chip unprotect only once every group is protected
              if (pfh_op_e'(i_req_op) == PFH_OP_UNPROT && (&prot_reg) == 1'b0)
              begin
                // refused: no pin moves, so the elevated reset must not come up either
                rsp_err_next = 1'b1;
                rsp_valid_next = 1'b1;
                ready_next = 1'b1;
                dq_oe_n_next = 16'hFFFF;
                rst_hv_next = 1'b0;
                addr_next = addr_reg;
                dq_o_next = dq_o_reg;
                byte_n_next = byte_n_reg;
              end
              else
              begin
                ce_n_next = 1'b0;
                state_next = PFH_ST_WRSET;
              end
            end
            PFH_OP_HWRESET:
            begin
              rst_n_next = 1'b0;
              dq_oe_n_next = 16'hFFFF;
              state_next = PFH_ST_RSTLOW;
            end
            default:
            begin
              rsp_err_next = 1'b1;
              rsp_valid_next = 1'b1;
              ready_next = 1'b1;
              dq_oe_n_next = 16'hFFFF;
            end
          endcase
        end
      end
      PFH_ST_RD:
      begin
        cnt_next = 8'(cnt_reg + 8'h01);
        // access time plus the two synchroniser stages
        if (cnt_reg == 8'(`PFH_ACC_CYC + `PFH_SYNC_CYC - 1))
          state_next = PFH_ST_RDCAP;
      end
      PFH_ST_RDCAP:
      begin
        rsp_data_next = byte_n_reg ? dq_s2_reg : {8'h00, dq_s2_reg[7:0]};
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        id_hv_next = 1'b0;
        // timeout flag on a status read: put the flash back in array read
        if (op_reg == PFH_OP_STATUS && dq_s2_reg[`PFH_TIMEOUT_BIT])
        begin
          rsp_err_next = 1'b1;
          op_next = PFH_OP_WRITE;
          ce_n_next = 1'b0;
          dq_o_next[14:0] = 15'(`PFH_RESET_CMD);
          dq_o_next[15] = byte_n_reg ? 1'b0 : dq_o_reg[15];
          dq_oe_n_next = byte_n_reg ? 16'h0000 : 16'h7F00;
          state_next = PFH_ST_WRSET;
        end
        else
        begin
          rsp_valid_next = 1'b1;
          ready_next = 1'b1;
          dq_oe_n_next = 16'hFFFF;
          state_next = PFH_ST_IDLE;
        end
      end
      PFH_ST_WRSET:
      begin
        we_n_next = 1'b0;
        cnt_next = 8'h00;
        state_next = PFH_ST_WRLOW;
      end
      PFH_ST_WRLOW:
      begin
        cnt_next = 8'(cnt_reg + 8'h01);
        if (cnt_reg == 8'(`PFH_WE_CYC - 1))
        begin
          we_n_next = 1'b1;
          state_next = PFH_ST_WRHIGH;
        end
      end
      PFH_ST_WRHIGH:
      begin
        // data held one cycle past the rising strobe
        ce_n_next = 1'b1;
        rst_hv_next = 1'b0;
        dq_oe_n_next = 16'hFFFF;
        if (op_reg == PFH_OP_PROTECT)
          prot_next[grp_reg] = 1'b1;
        if (op_reg == PFH_OP_UNPROT)
          prot_next = 24'h000000;
        rsp_valid_next = 1'b1;
        ready_next = 1'b1;
        state_next = PFH_ST_IDLE;
      end
      PFH_ST_RSTLOW:
      begin
        cnt_next = 8'(cnt_reg + 8'h01);
        if (cnt_reg == 8'(P_RP_CYC - 1))
        begin
          rst_n_next = 1'b1;
          cnt_next = 8'h00;
          state_next = PFH_ST_RSTREC;
        end
      end
      PFH_ST_RSTREC:
      begin
        cnt_next = 8'(cnt_reg + 8'h01);
        // flash is back in array read, no command needed
        if (cnt_reg == 8'(`PFH_RH_CYC - 1))
        begin
          rsp_valid_next = 1'b1;
          ready_next = 1'b1;
          state_next = PFH_ST_IDLE;
        end
      end
      default:
      begin
        state_next = PFH_ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // registers only; pins idle deselected with lanes released
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= PFH_ST_IDLE;
      op_reg <= PFH_OP_READ;
      cnt_reg <= 8'h00;
      grp_reg <= 5'h00;
      prot_reg <= 24'h000000;
      ready_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
      rsp_err_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      rst_n_reg <= 1'b1;
      rst_hv_reg <= 1'b0;
      id_hv_reg <= 1'b0;
      byte_n_reg <= 1'b1;
      addr_reg <= 21'h000000;
      dq_o_reg <= 16'h0000;
      dq_oe_n_reg <= 16'hFFFF;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      grp_reg <= grp_next;
      prot_reg <= prot_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_err_reg <= rsp_err_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      rst_n_reg <= rst_n_next;
      rst_hv_reg <= rst_hv_next;
      id_hv_reg <= id_hv_next;
      byte_n_reg <= byte_n_next;
      addr_reg <= addr_next;
      dq_o_reg <= dq_o_next;
      dq_oe_n_reg <= dq_oe_n_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_req_ready = ready_reg;
  assign o_rsp_valid = rsp_valid_reg;
  assign o_rsp_data = rsp_data_reg;
  assign o_rsp_err = rsp_err_reg;
  assign o_prot_map = prot_reg;
  assign o_ce_n = ce_n_reg;
  assign o_oe_n = oe_n_reg;
  assign o_we_n = we_n_reg;
  assign o_reset_n = rst_n_reg;
  assign o_reset_hv = rst_hv_reg;
  assign o_id_hv = id_hv_reg;
  assign o_byte_n = byte_n_reg;
  assign o_addr = addr_reg;
  assign o_dq = dq_o_reg;
  assign o_dq_oe_n = dq_oe_n_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_write_strobe_levels: assert property (!we_n_reg |-> !ce_n_reg && oe_n_reg)
    else $error("write strobe low without chip select low and output enable high");
  a_read_needs_select: assert property (!oe_n_reg |-> !ce_n_reg)
    else $error("output enable low while chip deselected");
  a_read_lanes_free: assert property (!oe_n_reg |-> dq_oe_n_reg[14:0] == 15'h7FFF)
    else $error("host drives data lanes during a read");
  a_byte_lane_use: assert property (!byte_n_reg && !ce_n_reg |-> !dq_oe_n_reg[15]
    && dq_oe_n_reg[14:8] == 7'h7F)
    else $error("byte mode lane use wrong");
  a_reset_pulse_len: assert property ($fell(rst_n_reg) |-> !rst_n_reg [*8])
    else $error("reset pulse shorter than reset pulse time");
  a_protect_hv_reset: assert property (!we_n_reg && (op_reg == PFH_OP_PROTECT
    || op_reg == PFH_OP_UNPROT) |-> rst_hv_reg)
    else $error("protect write without elevated reset");
  a_unprot_all_prot: assert property (state_reg == PFH_ST_WRSET && op_reg == PFH_OP_UNPROT
    |-> &prot_reg)
    else $error("unprotect issued with an unprotected group");
  a_timeout_reset: assert property (state_reg == PFH_ST_RDCAP && op_reg == PFH_OP_STATUS
    && dq_s2_reg[`PFH_TIMEOUT_BIT] |=> ##1 !we_n_reg
    && dq_o_reg[7:0] == 8'(`PFH_RESET_CMD))
    else $error("timeout flag not followed by reset command");
  a_id_hv_read: assert property (op_reg == PFH_OP_IDREAD && state_reg == PFH_ST_RD
    |-> id_hv_reg && !oe_n_reg)
    else $error("identification read without elevated id line");
  a_read_latency: assert property ($fell(oe_n_reg) |-> ##[4:5] rsp_valid_reg || rsp_err_reg)
    else $error("read answer not within access time");

  c_word_read: cover property (rsp_valid_reg && byte_n_reg && op_reg == PFH_OP_READ);
  c_byte_write: cover property (!we_n_reg && !byte_n_reg);
  c_protect_done: cover property (op_reg == PFH_OP_PROTECT && rsp_valid_reg);
  c_unprotect_done: cover property (op_reg == PFH_OP_UNPROT && rsp_valid_reg && !rsp_err_reg);
  c_timeout_fix: cover property (rsp_err_reg && state_reg == PFH_ST_WRSET);

endmodule : pfh_host

// [hdl/pfh_params.svh]
`ifndef PFH_PARAMS_SVH
`define PFH_PARAMS_SVH

// ****************************************
// clock and pin timing
// ****************************************
`define PFH_CLK_NS 50
`define PFH_ACC_NS 70
`define PFH_ACC_CYC ((`PFH_ACC_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_WE_NS 35
`define PFH_WE_CYC ((`PFH_WE_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_RP_NS 500
`define PFH_RP_CYC ((`PFH_RP_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_RH_NS 50
`define PFH_RH_CYC ((`PFH_RH_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_SYNC_CYC 2

// ****************************************
// pin fields and codes
// ****************************************
`define PFH_TIMEOUT_BIT 5
`define PFH_RESET_CMD 16'h00F0
`define PFH_GROUPS 24
`define PFH_ADDR_A6 6
`define PFH_ADDR_A1 1
`define PFH_ADDR_A0 0
`define PFH_ADDR_A9 9

`endif

// [hdl/pfh_pkg.sv]
package pfh_pkg;
  // request kinds offered on the user port
  typedef enum logic [2:0] {
    PFH_OP_READ = 3'h0,
    PFH_OP_WRITE = 3'h1,
    PFH_OP_STATUS = 3'h2,
    PFH_OP_HWRESET = 3'h3,
    PFH_OP_PROTECT = 3'h4,
    PFH_OP_UNPROT = 3'h5,
    PFH_OP_IDREAD = 3'h6
  } pfh_op_e;

  typedef enum logic [7:0] {
    PFH_ST_IDLE = 8'h01,
    PFH_ST_RD = 8'h02,
    PFH_ST_RDCAP = 8'h04,
    PFH_ST_WRSET = 8'h08,
    PFH_ST_WRLOW = 8'h10,
    PFH_ST_WRHIGH = 8'h20,
    PFH_ST_RSTLOW = 8'h40,
    PFH_ST_RSTREC = 8'h80
  } pfh_state_e;
endpackage : pfh_pkg

// [tb/pfh_flash_model.sv]
`timescale 1ns/100ps
// ****************************************
// behavioural flash seen through its pins
// ****************************************
module pfh_flash_model #(
  parameter logic [15:0] P_MAKER_ID = 16'h00A5, // arbitrary value, names no maker
  parameter logic [15:0] P_ID_CMD = 16'h0033 // stand-in code for command autoselect entry
)(
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_reset_n,
  input wire logic i_reset_hv,
  input wire logic i_id_hv,
  input wire logic i_byte_n,
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_fail,
  input wire logic i_guard_n,
  output logic [15:0] o_dq,
  output logic [15:0] o_en,
  output logic o_status,
  output logic o_viol
);
  logic [15:0] mem [0:255];
  logic [23:0] prot_reg = 24'h000000;
  logic id_mode = 1'b0;
  logic [4:0] grp;
  logic [15:0] word;
  logic [7:0] sel;
  logic [15:0] cmd;
  initial o_status = 1'b0;
  initial o_viol = 1'b0;
  // group decode from the top address pins
  always_comb
  begin
    if (i_addr[20:17] != 4'hF) grp = {1'b0, i_addr[20:17]};
    else if (i_addr[20:15] != 6'h3F) grp = 5'h0F;
    else grp = 5'h10 + {2'h0, i_addr[14:12]};
  end
  // read path; line 15 is the low address bit in byte width
  // data follows the address at once with no sleep latency; the status word stands in for array data once a fail is flagged
  assign word = (i_id_hv || id_mode) ? P_MAKER_ID :
    (o_status ? 16'h0020 : mem[i_addr[7:0]]);
  assign sel = i_dq[15] ? word[15:8] : word[7:0];
  assign o_dq = i_byte_n ? word : {8'h00, sel};
  assign o_en = (!i_ce_n && !i_oe_n && i_we_n && i_reset_n) ?
    (i_byte_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
  assign cmd = i_byte_n ? i_dq : {8'h00, i_dq[7:0]};
  // writes land on the rising write strobe, like the real part
  always @(posedge i_we_n or negedge i_reset_n or posedge i_fail)
  begin
    if (!i_reset_n)
    begin
      o_status <= 1'b0;
      id_mode <= 1'b0;
    end
    else if (i_fail) o_status <= 1'b1;
    else if (!i_ce_n)
    begin
      if (i_reset_hv) prot_reg <= i_addr[6] ? 24'h000000 : (prot_reg | (24'h1 << grp));
      else if (cmd == 16'h00F0)
      begin
        o_status <= 1'b0;
        id_mode <= 1'b0;
      end
      else if (cmd == P_ID_CMD) id_mode <= 1'b1;
      // top two boot sectors stay read-only while the guard pin is low
      else if (!i_guard_n && grp >= 5'h16) o_status <= o_status;
      // limitation: elevated reset only ever carries protect writes, so no temporary unprotect
      else if (prot_reg[grp]) o_status <= o_status;
      else if (i_byte_n) mem[i_addr[7:0]] <= i_dq;
      else if (i_dq[15]) mem[i_addr[7:0]][15:8] <= i_dq[7:0];
      else mem[i_addr[7:0]][7:0] <= i_dq[7:0];
    end
  end
  // a write strobe with output enable low is a bus fault
  always @(negedge i_we_n)
  begin
    if (i_ce_n !== 1'b0 || i_oe_n !== 1'b1) o_viol <= 1'b1;
  end
endmodule : pfh_flash_model

// [tb/pfh_host_tb.sv]
`timescale 1ns/100ps
module pfh_host_tb;
  import pfh_pkg::*;
  localparam logic [15:0] ID_CODE = 16'h00A5; // arbitrary value
  localparam logic [15:0] ID_CMD = 16'h0033; // stand-in autoselect entry code
  logic guard_n = 1'b1;
  logic mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, byte_mode = 1'b0, fail = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [21:0] req_addr = 22'h000000;
  logic [15:0] req_wdata = 16'h0000, dq_last = 16'h0000, got;
  logic ready, rsp_valid, rsp_err, ce_n, oe_n, we_n, reset_n, reset_hv, id_hv, byte_n, m_st, viol;
  logic [15:0] rsp_data, dq_w, dq_host, dq_oe_n, m_dq, m_en;
  logic [23:0] prot_map;
  logic [20:0] addr;
  logic err;
  int num_errors = 0, cmp_count = 0, rst_low = 0;
  always #25 mclk = ~mclk;
  // released lines show the inverse of their last level, never a held value
  assign dq_w = (~dq_oe_n & dq_host) | (dq_oe_n & m_en & m_dq) | (dq_oe_n & ~m_en & ~dq_last);
  // start from a known level so released lines never stay unknown
  always @(posedge mclk) dq_last <= (rst === 1'b1) ? 16'h0000 : dq_w;
  always @(posedge mclk) if (reset_n === 1'b0) rst_low++;
  pfh_host #(.P_RP_CYC(8)) u_pfh_host (.i_mclk(mclk), .i_rst(rst), .i_req_valid(req_valid),
    .i_req_op(req_op), .i_req_addr(req_addr), .i_req_wdata(req_wdata), .i_byte_mode(byte_mode),
    .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_rsp_err(rsp_err),
    .o_prot_map(prot_map), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_reset_n(reset_n),
    .o_reset_hv(reset_hv), .o_id_hv(id_hv), .o_byte_n(byte_n), .o_addr(addr), .i_dq(dq_w),
    .o_dq(dq_host), .o_dq_oe_n(dq_oe_n));
  pfh_flash_model #(.P_MAKER_ID(ID_CODE), .P_ID_CMD(ID_CMD)) u_pfh_flash_model (.i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(reset_n), .i_reset_hv(reset_hv), .i_id_hv(id_hv),
    .i_byte_n(byte_n), .i_addr(addr), .i_dq(dq_w), .i_fail(fail), .i_guard_n(guard_n),
    .o_dq(m_dq), .o_en(m_en),
    .o_status(m_st), .o_viol(viol));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] gotv, input logic [31:0] expv);
    cmp_count++;
    if (gotv !== expv)
    begin
      num_errors++;
      $display("ERROR at %0t got %h expected %h", $time, gotv, expv);
    end
  endtask : check
  // one request: held until the taking edge, then wait for the answer pulse
  task automatic xfer(input logic [2:0] op, input logic [21:0] a, input logic [15:0] wd,
                      input logic bm);
    int n;
    n = 0;
    while (ready !== 1'b1)
    begin
      if (n++ > 60) begin num_errors++; finish_test(); end
      @(posedge mclk);
      #5;
    end
    req_valid = 1'b1; req_op = op; req_addr = a; req_wdata = wd; byte_mode = bm;
    @(posedge mclk);
    #5 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1)
    begin
      if (n++ > 60) begin num_errors++; finish_test(); end
      @(posedge mclk);
      #5;
    end
    got = rsp_data;
    err = rsp_err;
  endtask : xfer
  function automatic logic [21:0] grp_addr(input int g);
    logic [8:0] h;
    if (g < 15) h = {g[3:0], 5'h00};
    else if (g == 15) h = 9'h1E0;
    else h = {6'h3F, 3'(g - 16)};
    return {h, 13'h0000};
  endfunction : grp_addr

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_width();
    xfer(3'h1, 22'h000020, 16'h1234, 1'b0);
    xfer(3'h0, 22'h000020, 16'h0000, 1'b0);
    check(got, 16'h1234);
    xfer(3'h0, 22'h000021, 16'h0000, 1'b1);
    check(got, 16'h0012);
    xfer(3'h1, 22'h000021, 16'h00AB, 1'b1);
    xfer(3'h0, 22'h000020, 16'h0000, 1'b0);
    check(got, 16'hAB34);
    $display("width test done");
  endtask : t_width
  task automatic t_protect();
    xfer(3'h1, {9'h1F8, 13'h0040}, 16'h5555, 1'b0);
    xfer(3'h4, grp_addr(16), 16'h0000, 1'b0);
    check(prot_map, 24'h010000);
    xfer(3'h1, {9'h1F8, 13'h0040}, 16'hAAAA, 1'b0);
    xfer(3'h0, {9'h1F8, 13'h0040}, 16'h0000, 1'b0);
    check(got, 16'h5555);
    xfer(3'h5, 22'h000000, 16'h0000, 1'b0);
    check({err, prot_map, reset_hv}, {1'b1, 24'h010000, 1'b0});
    for (int g = 0; g < 24; g++) xfer(3'h4, grp_addr(g), 16'h0000, 1'b0);
    check(prot_map, 24'hFFFFFF);
    xfer(3'h5, 22'h000000, 16'h0000, 1'b0);
    check({err, prot_map}, {1'b0, 24'h000000});
    xfer(3'h1, {9'h1F8, 13'h0040}, 16'hAAAA, 1'b0);
    xfer(3'h0, {9'h1F8, 13'h0040}, 16'h0000, 1'b0);
    check(got, 16'hAAAA);
    xfer(3'h1, {9'h1FF, 13'h0080}, 16'h1111, 1'b0);
    guard_n = 1'b0;
    xfer(3'h1, {9'h1FF, 13'h0080}, 16'h2222, 1'b0);
    guard_n = 1'b1;
    xfer(3'h0, {9'h1FF, 13'h0080}, 16'h0000, 1'b0);
    check(got, 16'h1111);
    $display("protect test done");
  endtask : t_protect
  task automatic t_status_reset();
    int base;
    fail = 1'b1;
    @(posedge mclk);
    #5 fail = 1'b0;
    xfer(3'h2, 22'h000020, 16'h0000, 1'b0);
    check({err, m_st}, 2'h2);
    fail = 1'b1;
    @(posedge mclk);
    #5 fail = 1'b0;
    base = rst_low;
    xfer(3'h3, 22'h000000, 16'h0000, 1'b0);
    check(rst_low - base, 8);
    xfer(3'h0, 22'h000020, 16'h0000, 1'b0);
    check(got, 16'hAB34);
    xfer(3'h6, 22'h000000, 16'h0000, 1'b0);
    check(got, ID_CODE);
    xfer(3'h1, 22'h000020, ID_CMD, 1'b0);
    xfer(3'h0, 22'h000020, 16'h0000, 1'b0);
    check(got, ID_CODE);
    xfer(3'h1, 22'h000020, 16'h00F0, 1'b0);
    xfer(3'h0, 22'h000020, 16'h0000, 1'b0);
    check(got, 16'hAB34);
    xfer(3'h7, 22'h000000, 16'h0000, 1'b0);
    check(err, 1'b1);
    check(viol, 1'b0);
    $display("status and reset test done");
  endtask : t_status_reset

  initial
  begin
    repeat (4) @(posedge mclk);
    #5 rst = 1'b0;
    t_width();
    t_protect();
    t_status_reset();
    finish_test();
  end
endmodule : pfh_host_tb
